// ### fbd_pkg.sv
// fbd_pkg: constants and carrier types for the fieldbus slave diagnostic,
// sync/freeze and clock rounding block.
// assumes a single 200 MHz module clock and an APB register port.
package fbd_pkg;

	// ==========================================================
	// timing
	localparam longint unsigned CLK_HZ      = 64'd200_000_000;
	localparam longint unsigned DIAG_HOLD_S = 64'd10;
	localparam logic [31:0] HOLD_CYCLES = 32'(DIAG_HOLD_S * CLK_HZ);
	localparam logic [31:0] SEC_CYCLES  = 32'(CLK_HZ);
	localparam logic [16:0] DAY_SECONDS = 17'h15180; // 86400
	localparam logic [16:0] HALF_HOUR_S = 17'h00708; // 1800
	localparam logic [16:0] QUARTER_S   = 17'h00384; // 900

	// ==========================================================
	// apb register offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_HDR   = 8'h04;
	localparam logic [7:0] OFS_LAST  = 8'h08;
	localparam logic [7:0] OFS_PRES  = 8'h0c;
	localparam logic [7:0] OFS_MODE  = 8'h10;
	localparam logic [7:0] OFS_TOD   = 8'h14;

	// ctrl field positions
	localparam int CTRL_REDUCED  = 0;
	localparam int CTRL_READY    = 1;
	localparam int CTRL_MAINT_LO = 2;
	localparam int CTRL_ABSENT   = 4;
	localparam int CTRL_OOS      = 5;
	localparam int CTRL_LINKDOWN = 6;
	localparam int CTRL_GROUP_LO = 8;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// diagnostic byte values and bit positions
	localparam logic [7:0] DIAG0_EXT   = 8'h08;
	localparam logic [7:0] DIAG7_EXT   = 8'h01;
	localparam logic [7:0] DIAG_NONE   = 8'h00;
	localparam int B18_MAINT_LO = 2;
	localparam int B18_ABSENT   = 4;
	localparam int B19_ADD      = 2;
	localparam int B19_REMOVE   = 3;
	localparam int B19_FAULT    = 4;

	// ==========================================================
	// carriers
	typedef enum logic [2:0] {
		FBD_EVT_ADD    = 3'b001,
		FBD_EVT_REMOVE = 3'b010,
		FBD_EVT_FAULT  = 3'b100
	} fbd_evt_e;

	typedef struct packed {
		logic       valid;
		fbd_evt_e   kind;
		logic [4:0] module_idx;
	} fbd_mod_evt_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] group;
		logic       sync;
		logic       unsync;
		logic       freeze;
		logic       unfreeze;
	} fbd_cmd_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} fbd_dx_s;

endpackage

// ### fbd_slave_diag.sv
// fbd_slave_diag: fieldbus slave diagnostic bytes, sync/freeze handling of
// cyclic data and half-hour rounding of the time-of-day clock.
// assumes the protocol engine and module-bus logic run on clock_i and hand
// over one-cycle strobes; the breaker input pins are asynchronous.
//
// Notes on behaviour
// - with external diagnostic pending, diagnostic byte 0 reads 08 instead of 00
// - byte 7 reads 01 while external diagnostic pending, else 00
// - external diagnostic only on not ready, maintenance, breaker absent, byte 19
// - bytes 24 to 27 hold one presence bit per module position
// - module add/remove/fault sets last-action bit, marks module, raises coming
// - diagnostic goes 10 s after coming when nothing else changes
// - last action and module stay until a later module event
// - added module enters presence list only when the diagnostic goes
// - removed module leaves presence list only when the diagnostic goes
// - a faulty module keeps its presence bit
// - reduced variant reports only none, out of service, link interrupted
// - no diagnostic interrupt; diagnostic bytes always readable
// - sync for our group moves buffered latest outputs to outputs and holds
// - unsync leaves sync mode; cyclic outputs applied at once
// - freeze latches inputs; refreshed only by another freeze
// - unfreeze updates inputs at once and resumes cyclic refresh
// - after restart neither sync nor freeze until first such command
// - in sync mode received control data is held until sync or unsync
// - clock-sync bit set plus sync rounds time of day to nearest half hour
//
// The APB slave port and the register addresses are this design's own decisions.
module fbd_slave_diag #(
	parameter logic [31:0] HOLD_CNT = fbd_pkg::HOLD_CYCLES,
	parameter logic [31:0] SEC_CNT  = fbd_pkg::SEC_CYCLES
) (
	input  wire logic                  clock_i,
	input  wire logic                  rst_i,
	// apb slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic [31:0]                prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// fieldbus protocol engine
	input  wire fbd_pkg::fbd_cmd_s     cmd_i,
	input  wire fbd_pkg::fbd_dx_s      dx_i,
	input  wire fbd_pkg::fbd_mod_evt_s mod_evt_i,
	// breaker side
	input  wire logic [15:0]           in_pins_i,
	output logic [15:0]                out_data_o,
	output logic [15:0]                in_data_o,
	output logic                       ext_diag_o,
	output logic [16:0]                tod_o
);
	import fbd_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		// software control word and time keeping
		logic [15:0] ctrl;
		logic [16:0] tod;
		logic [31:0] sec_cnt;
		logic [31:0] hold_cnt;
		// module-presence bookkeeping
		logic        coming;
		logic [2:0]  last_act;
		logic [31:0] last_mod;
		logic [31:0] presence;
		logic [31:0] pend_add;
		logic [31:0] pend_rem;
		// cyclic data paths and command modes
		logic [15:0] out_buf;
		logic [15:0] out_data;
		logic [15:0] in_data;
		logic        sync_mode;
		logic        freeze_mode;
		// pin synchroniser; only pin_sync is read by logic
		logic [15:0] pin_meta;
		logic [15:0] pin_sync;
	} fbd_state_s;

	fbd_state_s st;
	fbd_state_s next_st;

	// ==========================================================
	// decode helpers
	// 900 s rounds up; a result of a full day wraps to midnight
	function automatic logic [16:0] round_half_hour(input logic [16:0] t);
		logic [16:0] r;
		r = 17'(((t + QUARTER_S) / HALF_HOUR_S) * HALF_HOUR_S);
		if (r >= DAY_SECONDS)
			r = 17'h00000;
		return r;
	endfunction

	function automatic logic addressed(input logic [7:0] grp,
		input logic [7:0] mine);
		// group zero is a broadcast to every slave
		return (grp == 8'h00) || ((grp & mine) != 8'h00);
	endfunction

	// ==========================================================
	// diagnostic bytes
	logic        reduced;
	logic        ext_diag;
	logic [7:0]  diag_b0;
	logic [7:0]  diag_b7;
	logic [7:0]  diag_b18;
	logic [7:0]  diag_b19;
	logic [7:0]  my_group;
	logic        apb_wr;
	logic        apb_rd_ok;
	logic [31:0] rd_mux;

	assign reduced  = st.ctrl[CTRL_REDUCED];
	assign my_group = st.ctrl[CTRL_GROUP_LO +: 8];

	// reduced variant knows only two causes; module events never
	// reach it, so its byte 19 stays zero
	// the coming flag stands in for byte 19: last-action bits stay set
	// after the diagnostic goes, so they cannot be the trigger themselves
	always_comb
	begin
		if (reduced)
			ext_diag = st.ctrl[CTRL_OOS] | st.ctrl[CTRL_LINKDOWN];
		else
			ext_diag = ~st.ctrl[CTRL_READY]
				| (st.ctrl[CTRL_MAINT_LO +: 2] != 2'b00)
				| st.ctrl[CTRL_ABSENT]
				| st.coming;
		diag_b0  = ext_diag ? DIAG0_EXT : DIAG_NONE;
		diag_b7  = ext_diag ? DIAG7_EXT : DIAG_NONE;
		diag_b18 = 8'h00;
		diag_b19 = 8'h00;
		if (!reduced)
		begin
			diag_b18[B18_MAINT_LO +: 2] = st.ctrl[CTRL_MAINT_LO +: 2];
			diag_b18[B18_ABSENT]        = st.ctrl[CTRL_ABSENT];
			diag_b19[B19_ADD]           = st.last_act[0];
			diag_b19[B19_REMOVE]        = st.last_act[1];
			diag_b19[B19_FAULT]         = st.last_act[2];
		end
	end

	// ==========================================================
	// apb slave: zero wait states, error on unmapped offsets
	assign apb_wr = psel_i & penable_i & pwrite_i;

	// one write strobe per register; shared by every writable offset
	function automatic logic wr_hit(input logic [7:0] ofs);
		return apb_wr && (paddr_i == ofs);
	endfunction

	// diagnostics are plain readable registers, never an interrupt
	always_comb
	begin
		apb_rd_ok = 1'b1;
		rd_mux    = 32'h0000_0000;
		unique case (paddr_i)
			OFS_CTRL: rd_mux = {16'h0000, st.ctrl};
			OFS_HDR:  rd_mux = {diag_b19, diag_b18, diag_b7, diag_b0};
			OFS_LAST: rd_mux = reduced ? 32'h0000_0000 : st.last_mod;
			OFS_PRES: rd_mux = reduced ? 32'h0000_0000 : st.presence;
			OFS_MODE: rd_mux = {29'h0000_0000, st.coming, st.freeze_mode,
				st.sync_mode};
			OFS_TOD:  rd_mux = {15'h0000, st.tod};
			default:  apb_rd_ok = 1'b0;
		endcase
	end

	// pready is tied high: every register is a flop or a mux, so no
	// access ever needs a wait state
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~apb_rd_ok;
	assign prdata_o  = (psel_i & apb_rd_ok) ? rd_mux : 32'h0000_0000;

	// ==========================================================
	// next-state logic
	always_comb
	begin
		logic        cmd_hit;
		logic        sync_cmd;
		logic [15:0] latest;
		cmd_hit  = 1'b0;
		sync_cmd = 1'b0;
		latest   = 16'h0000;
		next_st  = st;

		// two-stage synchroniser on the breaker input pins
		next_st.pin_meta = in_pins_i;
		next_st.pin_sync = st.pin_meta;

		// register writes
		if (wr_hit(OFS_CTRL))
			next_st.ctrl = pwdata_i[15:0];

		// the one-second tick keeps running in sync mode; only the rounding
		// step and a software time load touch the seconds
		// time of day: one-second tick, loaded by software
		if (st.sec_cnt >= SEC_CNT - 32'h0000_0001)
		begin
			next_st.sec_cnt = 32'h0000_0000;
			next_st.tod = (st.tod >= DAY_SECONDS - 17'h00001) ? 17'h00000
				: st.tod + 17'h00001;
		end
		else
			next_st.sec_cnt = st.sec_cnt + 32'h0000_0001;
		if (wr_hit(OFS_TOD))
		begin
			next_st.tod     = pwdata_i[16:0];
			next_st.sec_cnt = 32'h0000_0000;
		end

		// the buffer keeps the last frame even when no frame arrives, so a
		// later sync still finds data to move
		// cyclic output data always lands in the transfer buffer first
		latest = dx_i.valid ? dx_i.data : st.out_buf;
		next_st.out_buf = latest;
		if (!st.sync_mode)
			next_st.out_data = latest;
		// while synced the outputs stay put until the next sync or unsync command

		// freeze and unfreeze both sample the synchronised pins, never the
		// raw ones, so a metastable bit cannot reach the master
		// cyclic input refresh unless frozen
		if (!st.freeze_mode)
			next_st.in_data = st.pin_sync;

		// broadcast control commands; a slave may sit in several groups,
		// so any group bit shared with the configured mask is matched
		// sync copies latest, which already holds a frame of this cycle
		cmd_hit = cmd_i.valid && addressed(cmd_i.group, my_group);
		if (cmd_hit)
		begin
			if (cmd_i.sync)
			begin
				sync_cmd          = 1'b1;
				next_st.sync_mode = 1'b1;
				next_st.out_data  = latest;
			end
			else if (cmd_i.unsync)
			begin
				next_st.sync_mode = 1'b0;
				next_st.out_data  = latest;
			end
			if (cmd_i.freeze)
			begin
				next_st.freeze_mode = 1'b1;
				next_st.in_data     = st.pin_sync;
			end
			else if (cmd_i.unfreeze)
			begin
				next_st.freeze_mode = 1'b0;
				next_st.in_data     = st.pin_sync;
			end
		end

		// clock-sync bit is bit 7 of control byte 1 in the latest frame;
		// the rounding beats a software time load in the same cycle
		if (sync_cmd && latest[15])
		begin
			next_st.tod     = round_half_hour(st.tod);
			next_st.sec_cnt = 32'h0000_0000;
		end

		// pending masks keep presence steady while the diagnostic stands;
		// the master sees the new list only after the diagnostic goes
		// outgoing diagnostic: commit pending presence changes
		if (st.coming)
		begin
			if (st.hold_cnt >= HOLD_CNT - 32'h0000_0001)
			begin
				next_st.coming   = 1'b0;
				next_st.hold_cnt = 32'h0000_0000;
				next_st.presence = (st.presence | st.pend_add)
					& ~st.pend_rem;
				next_st.pend_add = 32'h0000_0000;
				next_st.pend_rem = 32'h0000_0000;
			end
			else
				next_st.hold_cnt = st.hold_cnt + 32'h0000_0001;
		end

		// a fault leaves both pending masks alone, so an earlier add or
		// remove of the same module still commits on expiry
		// module events win over the expiry in the same cycle
		if (mod_evt_i.valid && !reduced)
		begin
			next_st.coming   = 1'b1;
			next_st.hold_cnt = 32'h0000_0000;
			next_st.last_act = mod_evt_i.kind;
			next_st.last_mod = 32'h0000_0001 << mod_evt_i.module_idx;
			unique case (mod_evt_i.kind)
				FBD_EVT_ADD:
				begin
					next_st.pend_add[mod_evt_i.module_idx] = 1'b1;
					next_st.pend_rem[mod_evt_i.module_idx] = 1'b0;
				end
				FBD_EVT_REMOVE:
				begin
					next_st.pend_rem[mod_evt_i.module_idx] = 1'b1;
					next_st.pend_add[mod_evt_i.module_idx] = 1'b0;
				end
				FBD_EVT_FAULT: ;
				default: ;
			endcase
			// an expiry in this cycle already committed older changes
			if (st.coming && st.hold_cnt >= HOLD_CNT - 32'h0000_0001)
			begin
				next_st.pend_add = 32'h0000_0000;
				next_st.pend_rem = 32'h0000_0000;
				if (mod_evt_i.kind == FBD_EVT_ADD)
					next_st.pend_add[mod_evt_i.module_idx] = 1'b1;
				if (mod_evt_i.kind == FBD_EVT_REMOVE)
					next_st.pend_rem[mod_evt_i.module_idx] = 1'b1;
			end
		end
	end

	// ==========================================================
	// a full clear is cheaper than per-field reset values; only ctrl
	// carries a named reset word
	// state register; restart leaves both modes off
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			st      <= '0;
			st.ctrl <= CTRL_RESET;
		end
		else
			st <= next_st;
	end

	// data outputs come straight from flops; ext_diag is a level
	// decoded from flops, safe to sample on any edge
	assign out_data_o = st.out_data;
	assign in_data_o  = st.in_data;
	assign tod_o      = st.tod;
	assign ext_diag_o = ext_diag;

endmodule

// ### fbd_slave_diag_asserts.sv
// checker for fbd_slave_diag, bound from the bench top file
// assumes group mask and status reach the block only through ctrl writes
module fbd_sd_chk
	import fbd_pkg::*;
#(
	parameter logic [31:0] HOLD_CNT = 32'd50
) (
	input wire logic                  clock_i,
	input wire logic                  rst_i,
	input wire logic                  psel_i,
	input wire logic                  penable_i,
	input wire logic                  pwrite_i,
	input wire logic [7:0]            paddr_i,
	input wire logic [31:0]           pwdata_i,
	input wire logic [31:0]           prdata_o,
	input wire logic                  pready_o,
	input wire fbd_pkg::fbd_cmd_s     cmd_i,
	input wire fbd_pkg::fbd_dx_s      dx_i,
	input wire fbd_pkg::fbd_mod_evt_s mod_evt_i,
	input wire logic [15:0]           out_data_o,
	input wire logic [15:0]           in_data_o,
	input wire logic                  ext_diag_o,
	input wire logic                  pslverr_o,
	input wire logic [16:0]           tod_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// mirror of ctrl, modes and hold count
	logic [15:0] ctrl;
	logic        sync_m;
	logic        frz_m;
	logic [31:0] cnt;
	logic        tk;
	logic        ok;
	assign tk = cmd_i.valid && (cmd_i.group == 8'h00
		|| (cmd_i.group & ctrl[15:8]) != 8'h00);
	assign ok = ctrl[1] && ctrl[3:2] == 2'b00 && !ctrl[4] && !ctrl[0];
	// count stops one past the hold so the expiry cycle stays visible
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			ctrl <= 16'h0000;
			sync_m <= 1'b0;
			frz_m <= 1'b0;
			cnt <= 32'h0;
		end
		else
		begin
			if (psel_i && penable_i && pwrite_i && paddr_i == OFS_CTRL)
				ctrl <= pwdata_i[15:0];
			if (tk && (cmd_i.sync || cmd_i.unsync))
				sync_m <= cmd_i.sync;
			if (tk && (cmd_i.freeze || cmd_i.unfreeze))
				frz_m <= cmd_i.freeze;
			if (mod_evt_i.valid && !ctrl[0])
				cnt <= 32'h1;
			else if (cnt != 32'h0 && cnt <= HOLD_CNT)
				cnt <= cnt + 32'h1;
		end
	end
	// ==========
	// properties
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_sync_tk;
		tk && cmd_i.sync && dx_i.valid;
	endsequence
	property p_hdr;
		psel_i && paddr_i == OFS_HDR |->
			prdata_o[15:0] == (ext_diag_o ? 16'h0108 : 16'h0000);
	endproperty
	a_hdr: assert property (p_hdr) else $error("header byte 0/7 wrong");
	property p_rdy;
		psel_i && penable_i |-> pready_o;
	endproperty
	a_rdy: assert property (p_rdy) else $error("read stalled");
	property p_cause;
		!ctrl[0] && !ok |-> ext_diag_o;
	endproperty
	a_cause: assert property (p_cause) else $error("status not flagged");
	property p_red;
		ctrl[0] |-> ext_diag_o == (ctrl[5] | ctrl[6]);
	endproperty
	a_red: assert property (p_red) else $error("reduced flag wrong");
	property p_on;
		cnt != 32'h0 && cnt <= HOLD_CNT && !ctrl[0] |-> ext_diag_o;
	endproperty
	a_on: assert property (p_on) else $error("coming lost early");
	property p_off;
		cnt == HOLD_CNT + 32'h1 && ok |-> !ext_diag_o;
	endproperty
	a_off: assert property (p_off) else $error("diag did not go");
	property p_sync_hold;
		sync_m && !tk |=> $stable(out_data_o);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("sync leak");
	property p_cyc_out;
		!sync_m && !tk && dx_i.valid |=> out_data_o == $past(dx_i.data);
	endproperty
	a_cyc_out: assert property (p_cyc_out) else $error("cyclic out");
	property p_sync_copy;
		s_sync_tk |=> out_data_o == $past(dx_i.data);
	endproperty
	a_sync_copy: assert property (p_sync_copy) else $error("sync copy");
	property p_frz_hold;
		frz_m && !tk |=> $stable(in_data_o);
	endproperty
	a_frz_hold: assert property (p_frz_hold) else $error("freeze leak");
	property p_err;
		psel_i && penable_i && paddr_i > OFS_TOD |-> pslverr_o;
	endproperty
	a_err: assert property (p_err) else $error("no error on hole");
	property p_tod;
		psel_i && paddr_i == OFS_TOD |-> prdata_o[16:0] == tod_o;
	endproperty
	a_tod: assert property (p_tod) else $error("time read wrong");
endmodule

// ### fbd_dp_master.sv
// partner: fieldbus master sending control commands and cyclic frames
// assumes the bench calls xfer right after a rising edge of clock_i
module fbd_dp_master
	import fbd_pkg::*;
(
	input  wire logic          clock_i,
	output fbd_pkg::fbd_cmd_s  cmd_o,
	output fbd_pkg::fbd_dx_s   dx_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmd_o = '0;
		dx_o = '0;
	end
	// one frame: op is sync,unsync,freeze,unfreeze; one group bit only
	// bench loads the time, then sends sync with the clock-sync bit set in that same frame
	// released lines show inverted data so stale values never pass
	task automatic xfer(input logic [7:0] g, input logic [3:0] op,
		input logic dv, input logic [15:0] d);
		@(posedge clock_i);
		cmd_o <= {op != 4'h0, g, op};
		dx_o <= {dv, d};
		@(posedge clock_i);
		cmd_o <= {1'b0, ~g, 4'h0};
		dx_o <= {1'b0, ~d};
	endtask
endmodule

// ### fbd_slave_diag_tb_top.sv
// bench top: fbd_slave_diag, master model, queue-checked results
// assumes short hold (50) and second (10) counts for a brief run
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	num_errors++; $display("Error %0t: got %h", $time, g); end end
module fbd_slave_diag_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fbd_pkg::*;
	localparam logic [31:0] HOLD = 32'd50;
	localparam logic [15:0] CT [8] = '{16'h0000, 16'h0002, 16'h0006,
		16'h000e, 16'h0012, 16'h0021, 16'h0041, 16'h0001};
	localparam logic [31:0] HD [8] = '{32'h108, 32'h0, 32'h40108,
		32'hc0108, 32'h100108, 32'h108, 32'h108, 32'h0};
	localparam fbd_evt_e EK [3] = '{FBD_EVT_ADD, FBD_EVT_FAULT, FBD_EVT_REMOVE};
	localparam logic [31:0] PB [3] = '{32'h0, 32'h1, 32'h1};
	localparam logic [31:0] PA [3] = '{32'h1, 32'h1, 32'h0};
	localparam logic [31:0] TS [3] = '{32'h0a8b, 32'h0a8c, 32'h1517f};
	localparam logic [31:0] TE [3] = '{32'h708, 32'he10, 32'h0};
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        pk = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] got;
	logic        pready;
	logic        ext_diag;
	logic [15:0] pins = 16'h0;
	logic [15:0] out_data;
	logic [15:0] in_data;
	logic [15:0] a;
	logic [15:0] b;
	logic [4:0]  m;
	fbd_cmd_s     cmd;
	fbd_dx_s      dx;
	fbd_mod_evt_s evt = '0;
	logic [31:0] eq[$];
	integer      seed = 32'h72bc;
	int          num_errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	fbd_slave_diag #(.HOLD_CNT(HOLD), .SEC_CNT(32'd10)) dut_u (
		.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(), .cmd_i(cmd), .dx_i(dx), .mod_evt_i(evt),
		.in_pins_i(pins), .out_data_o(out_data), .in_data_o(in_data),
		.ext_diag_o(ext_diag), .tod_o());
	fbd_dp_master m_u (.clock_i(clock_i), .cmd_o(cmd), .dx_o(dx));
	// ==========
	// clock and hang guard
	initial
	begin
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			close_out();
		end
	end
	// monitor: oldest note against the result shown this cycle
	assign got = pk ? {in_data, out_data} : prdata;
	always @(posedge clock_i)
	begin
		if (pk || (psel && penable && pready && !pwrite))
			`CHK(got, eq.pop_front())
	end
	// ==========
	// drivers
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] wd);
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e);
		eq.push_back(e);
		apb(1'b0, ad, 32'h0);
	endtask
	task automatic see(input logic [31:0] e);
		eq.push_back(e);
		@(posedge clock_i);
		pk <= 1'b1;
		@(posedge clock_i);
		pk <= 1'b0;
	endtask
	task automatic ev(input fbd_evt_e k, input logic [4:0] i);
		@(posedge clock_i);
		evt <= '{1'b1, k, i};
		@(posedge clock_i);
		evt.valid <= 1'b0;
	endtask
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// ==========
	// main sequence
	initial
	begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(OFS_MODE, 32'h0);
		rd(8'h18, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, OFS_CTRL, {16'h0, CT[i]});
			rd(OFS_HDR, HD[i]);
		end
		ev(FBD_EVT_ADD, 5'h05);
		rd(OFS_LAST, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0402);
		m = 5'($random(seed));
		for (int k = 0; k < 3; k++)
		begin
			ev(EK[k], m);
			rd(OFS_HDR, {3'b0, EK[k], 26'h108});
			rd(OFS_LAST, 32'h1 << m);
			rd(OFS_PRES, PB[k] << m);
			repeat (HOLD) @(posedge clock_i);
			rd(OFS_HDR, {3'b0, EK[k], 26'h0});
			rd(OFS_PRES, PA[k] << m);
		end
		// sync: buffered data held until the next sync
		pins <= 16'($random(seed));
		a = 16'($random(seed));
		m_u.xfer(8'h00, 4'h0, 1'b1, a);
		see({pins, a});
		m_u.xfer(8'h04, 4'h8, 1'b0, 16'h0);
		m_u.xfer(8'h00, 4'h0, 1'b1, ~a);
		see({pins, a});
		m_u.xfer(8'h04, 4'h8, 1'b1, a ^ 16'h00ff);
		see({pins, a ^ 16'h00ff});
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, OFS_TOD, TS[i]);
			m_u.xfer(8'h04, 4'h8, 1'b1, 16'h8000);
			rd(OFS_TOD, TE[i]);
		end
		m_u.xfer(8'h08, 4'h4, 1'b1, a);
		see({pins, 16'h8000});
		m_u.xfer(8'h00, 4'h4, 1'b0, 16'h0);
		see({pins, a});
		// freeze: inputs held across pin changes
		b = pins;
		m_u.xfer(8'h04, 4'h2, 1'b0, 16'h0);
		pins <= ~b;
		repeat (4) @(posedge clock_i);
		see({b, a});
		m_u.xfer(8'h04, 4'h2, 1'b0, 16'h0);
		pins <= b;
		repeat (4) @(posedge clock_i);
		see({~b, a});
		m_u.xfer(8'h04, 4'h1, 1'b0, 16'h0);
		see({b, a});
		rd(OFS_MODE, 32'h0);
		close_out();
	end
endmodule
bind fbd_slave_diag fbd_sd_chk #(.HOLD_CNT(HOLD_CNT)) chk_u (.*);
